// File: rtl/srcc_defs.vh
// Purpose: Named constants for the status reporting and common command block.
// Assumes: Included by every design file of the block by its bare name.
// Notes:   Definitions only; no logic lives here.
`ifndef SRCC_DEFS_VH
`define SRCC_DEFS_VH

// ============================================================
// Command codes delivered by the command parser
// ============================================================
`define SRCC_CODE_W 4
`define SRCC_CMD_CLEAR_STATUS 4'h0
`define SRCC_CMD_EVT_MASK_SET 4'h1
`define SRCC_CMD_EVT_MASK_QRY 4'h2
`define SRCC_CMD_EVT_STAT_QRY 4'h3
`define SRCC_CMD_IDENT_QRY 4'h4
`define SRCC_CMD_OP_DONE_SET 4'h5
`define SRCC_CMD_OP_DONE_QRY 4'h6
`define SRCC_CMD_RESET 4'h7
`define SRCC_CMD_SVC_MASK_SET 4'h8
`define SRCC_CMD_SVC_MASK_QRY 4'h9
`define SRCC_CMD_SUMMARY_QRY 4'hA

// ============================================================
// Value field and limits
// ============================================================
`define SRCC_VAL_W 16
`define SRCC_VAL_MAX 16'h00FF

// ============================================================
// Event status latch bit positions and reset value
// ============================================================
`define SRCC_EVT_OP_DONE_BIT 0
`define SRCC_EVT_QUERY_ERR_BIT 2
`define SRCC_EVT_DEV_ERR_BIT 3
`define SRCC_EVT_EXEC_ERR_BIT 4
`define SRCC_EVT_CMD_ERR_BIT 5
`define SRCC_EVT_POWER_ON_BIT 7
`define SRCC_EVT_USED_MASK 8'hBD
`define SRCC_EVT_RESET 8'h80

// ============================================================
// Status summary byte bit positions and mask reset
// ============================================================
`define SRCC_STAT_MSG_AVAIL_BIT 4
`define SRCC_STAT_EVT_SUM_BIT 5
`define SRCC_STAT_REQ_SVC_BIT 6
`define SRCC_SVC_MASK_BIT6_CLR 8'hBF
`define SRCC_MASK_RESET 8'h00

// ============================================================
// Output queue and characters
// ============================================================
`define SRCC_CNT_W 6
`define SRCC_DEC_W 32
`define SRCC_CHR_LF 8'h0A
`define SRCC_CHR_CR 8'h0D
`define SRCC_CHR_ONE 8'h31
`define SRCC_DIGIT_HI 4'h3
`define SRCC_HUNDRED 8'h64
`define SRCC_TEN 8'h0A
`define SRCC_LEN_ONE 6'h01
`define SRCC_LEN_TWO 6'h02
`define SRCC_LEN_THREE 6'h03
`define SRCC_LEN_FOUR 6'h04

`endif

// File: rtl/srcc_out_queue.v
// Purpose: Byte queue that sends one response to the host, first byte first.
// Assumes: One response at a time; a load replaces whatever is still held.
// Notes:   term_sent pulses one cycle after the last byte is taken.
`timescale 1ns/1ps
`default_nettype none
`include "srcc_defs.vh"

module srcc_out_queue #(
  parameter DEPTH = 32
) (
  input wire core_clk,
  input wire rst_b,
  input wire flush,
  input wire load,
  input wire [`SRCC_CNT_W-1:0] load_len,
  input wire [8*DEPTH-1:0] load_data,
  input wire out_ready,
  output reg out_valid,
  output wire [7:0] out_data,
  output reg term_sent
);

  reg [8*DEPTH-1:0] text_ff;
  reg [`SRCC_CNT_W-1:0] cnt_ff;

  // ============================================================
  // Shift register; the byte on the wire is the top byte.
  // ============================================================
  assign out_data = text_ff[8*DEPTH-1 -: 8];

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      text_ff <= {(8*DEPTH){1'b0}};
      cnt_ff <= {`SRCC_CNT_W{1'b0}};
      out_valid <= 1'b0;
      term_sent <= 1'b0;
    end else begin
      term_sent <= 1'b0;
      if (load) begin
        text_ff <= load_data;
        cnt_ff <= load_len;
        out_valid <= (load_len != {`SRCC_CNT_W{1'b0}});
      end else if (flush) begin
        cnt_ff <= {`SRCC_CNT_W{1'b0}};
        out_valid <= 1'b0;
      end else if (out_valid && out_ready) begin
        text_ff <= {text_ff[8*DEPTH-9:0], 8'h00};
        cnt_ff <= cnt_ff - `SRCC_LEN_ONE;
        out_valid <= (cnt_ff != `SRCC_LEN_ONE);
        term_sent <= (cnt_ff == `SRCC_LEN_ONE);
      end
    end
  end

endmodule // srcc_out_queue

`default_nettype wire

// File: rtl/srcc_status_core.v
// Purpose: Status summary, service request and common command handling.
// Assumes: Commands arrive already parsed, on core_clk, from either link.
// Notes:   Query answers other than identity are decimal text closed by a line feed.
//
// Behaviour
// - An 8-bit service request mask gates status byte summary bits.
// - Mask bit n gates status bit n; 48 enables bits 4 and 5.
// - A set mask bit lets the request-service bit 6 be raised.
// - Service mask clears at power-up and on every device clear.
// - Service mask query answers in decimal with bit 6 as zero.
// - Clear status empties event latches; message flag only if first.
// - Event mask set loads a value 0 to 255.
// - Out-of-range event mask value is not loaded; flags execution error.
// - Event mask query returns the last loaded value in decimal.
// - Event status query returns the latch then clears it.
// - Identity query returns maker, model, serial, versions fields.
// - Operation-complete command sets the operation-complete bit.
// - Operation-complete query queues the ASCII character 1.
// - Reset command resets the meter but keeps interface status.
// - Serial control-C acts as device clear and sends CR LF prompt.
// - Both links share one command path and one behaviour.
// - Event summary sets on an enabled event rise; clears on read.
// - Event latch bits 0,2,3,4,5,7 used; bits 1 and 6 read zero.
// - Message flag sets on queued answer, clears when terminator sent.
// - Serial poll reads and clears request-service; query leaves it.
`timescale 1ns/1ps
`default_nettype none
`include "srcc_defs.vh"

module srcc_status_core #(
  parameter Q_DEPTH = 32,
  parameter IDN_LEN = 26,
  // Identity text; the value is arbitrary.
  parameter [8*IDN_LEN-1:0] IDN_TEXT = "ACME,MTR1,0000001,1.0 D1.0",
  // Prompt character sent after control-C; the value is arbitrary.
  parameter [7:0] PROMPT_CHAR = 8'h3E
) (
  input wire core_clk,
  input wire rst_b,
  input wire cmd_valid,
  input wire [`SRCC_CODE_W-1:0] cmd_code,
  input wire [`SRCC_VAL_W-1:0] cmd_value,
  input wire cmd_first,
  input wire dev_clear,
  input wire ctrl_c,
  input wire query_err_evt,
  input wire dev_err_evt,
  input wire cmd_err_evt,
  input wire spoll_req,
  input wire out_ready,
  output wire out_valid,
  output wire [7:0] out_data,
  output reg [7:0] spoll_byte_ff,
  output reg srq_ff,
  output reg meter_reset_ff,
  output reg [7:0] service_request_mask_ff,
  output reg [7:0] event_status_latch_ff
);

  // ============================================================
  // Constants and helpers
  // ============================================================
  localparam [31:0] IDN_RESP_W = IDN_LEN + 1;
  localparam [`SRCC_CNT_W-1:0] IDN_RESP_LEN = IDN_RESP_W[`SRCC_CNT_W-1:0];
  localparam PAD_DEC = 8*Q_DEPTH - `SRCC_DEC_W;
  localparam PAD_IDN = 8*(Q_DEPTH - IDN_LEN - 1);
  localparam PAD_PROMPT = 8*(Q_DEPTH - 3);

  // ASCII digit of a value below ten.
  function [7:0] asc;
    input [7:0] d;
    begin
      asc = {`SRCC_DIGIT_HI, d[3:0]};
    end
  endfunction

  // Decimal text of a byte, left aligned, line feed closing it.
  // Result is {length, text}; leading zeros are dropped.
  function [`SRCC_CNT_W+`SRCC_DEC_W-1:0] dec_text;
    input [7:0] v;
    reg [7:0] h;
    reg [7:0] t;
    reg [7:0] o;
    begin
      h = v / `SRCC_HUNDRED;
      t = (v / `SRCC_TEN) % `SRCC_TEN;
      o = v % `SRCC_TEN;
      if (h != 8'h00) begin
        dec_text = {`SRCC_LEN_FOUR, asc(h), asc(t), asc(o), `SRCC_CHR_LF};
      end else if (t != 8'h00) begin
        dec_text = {`SRCC_LEN_THREE, asc(t), asc(o), `SRCC_CHR_LF, 8'h00};
      end else begin
        dec_text = {`SRCC_LEN_TWO, asc(o), `SRCC_CHR_LF, 16'h0000};
      end
    end
  endfunction

  // ============================================================
  // State
  // ============================================================
  reg [7:0] event_enable_mask_ff;
  reg event_summary_flag_ff;
  reg message_available_flag_ff;
  reg request_service_flag_ff;
  reg mss_prev_ff;

  reg [7:0] nxt_service_request_mask;
  reg [7:0] nxt_event_enable_mask;
  reg [7:0] nxt_event_status_latch;
  reg nxt_event_summary_flag;
  reg nxt_message_available_flag;
  reg nxt_request_service_flag;
  reg [7:0] new_events;
  reg evt_clear;
  reg q_flush;
  reg q_load;
  reg [`SRCC_CNT_W-1:0] q_len;
  reg [8*Q_DEPTH-1:0] q_data;
  reg [`SRCC_CNT_W+`SRCC_DEC_W-1:0] dec_sel;
  reg nxt_meter_reset;

  wire term_sent;
  wire any_clear;
  wire take;
  wire is_query;
  wire query_ok;
  wire value_ok;
  wire known_cmd;
  wire [7:0] status_bits;
  wire master_summary_flag;
  wire mss_rise;

  // ============================================================
  // Command decode
  // ============================================================
  // Device clear on the bus and control-C on the serial link take the
  // same path; a command arriving in that cycle is dropped on purpose.
  assign any_clear = dev_clear | ctrl_c;
  assign take = cmd_valid & ~any_clear;
  assign is_query = (cmd_code == `SRCC_CMD_EVT_MASK_QRY) ||
                    (cmd_code == `SRCC_CMD_EVT_STAT_QRY) ||
                    (cmd_code == `SRCC_CMD_IDENT_QRY) ||
                    (cmd_code == `SRCC_CMD_OP_DONE_QRY) ||
                    (cmd_code == `SRCC_CMD_SVC_MASK_QRY) ||
                    (cmd_code == `SRCC_CMD_SUMMARY_QRY);
  assign known_cmd = is_query ||
                     (cmd_code == `SRCC_CMD_CLEAR_STATUS) ||
                     (cmd_code == `SRCC_CMD_EVT_MASK_SET) ||
                     (cmd_code == `SRCC_CMD_OP_DONE_SET) ||
                     (cmd_code == `SRCC_CMD_RESET) ||
                     (cmd_code == `SRCC_CMD_SVC_MASK_SET);
  // An answer still unread blocks the next query, which is then a
  // query error instead of overwriting the pending answer.
  assign query_ok = take & is_query & ~out_valid;
  assign value_ok = (cmd_value <= `SRCC_VAL_MAX);

  // ============================================================
  // Status summary byte and service request
  // ============================================================
  assign status_bits = {1'b0, 1'b0, event_summary_flag_ff,
                        message_available_flag_ff, 4'h0};
  // Bit 6 of the mask is never stored, so it never gates anything.
  assign master_summary_flag =
    |(status_bits & service_request_mask_ff);
  assign mss_rise = master_summary_flag & ~mss_prev_ff;

  // ============================================================
  // Next-state logic
  // ============================================================
  always @* begin
    nxt_service_request_mask = service_request_mask_ff;
    nxt_event_enable_mask = event_enable_mask_ff;
    new_events = 8'h00;
    evt_clear = 1'b0;
    nxt_message_available_flag = message_available_flag_ff;
    q_flush = 1'b0;
    nxt_meter_reset = 1'b0;
    if (any_clear) begin
      nxt_service_request_mask = `SRCC_MASK_RESET;
      nxt_message_available_flag = 1'b0;
      q_flush = 1'b1;
    end
    new_events[`SRCC_EVT_QUERY_ERR_BIT] = query_err_evt;
    new_events[`SRCC_EVT_DEV_ERR_BIT] = dev_err_evt;
    new_events[`SRCC_EVT_CMD_ERR_BIT] = cmd_err_evt | (take & ~known_cmd);
    if (take && is_query && !query_ok) begin
      new_events[`SRCC_EVT_QUERY_ERR_BIT] = 1'b1;
    end
    if (take) begin
      case (cmd_code)
        `SRCC_CMD_CLEAR_STATUS: begin
          evt_clear = 1'b1;
          if (cmd_first) begin
            nxt_message_available_flag = 1'b0;
            q_flush = 1'b1;
          end
        end
        `SRCC_CMD_EVT_MASK_SET: begin
          if (value_ok) begin
            nxt_event_enable_mask = cmd_value[7:0];
          end else begin
            new_events[`SRCC_EVT_EXEC_ERR_BIT] = 1'b1;
          end
        end
        `SRCC_CMD_SVC_MASK_SET: begin
          if (value_ok) begin
            nxt_service_request_mask =
              cmd_value[7:0] & `SRCC_SVC_MASK_BIT6_CLR;
          end else begin
            new_events[`SRCC_EVT_EXEC_ERR_BIT] = 1'b1;
          end
        end
        `SRCC_CMD_OP_DONE_SET: begin
          new_events[`SRCC_EVT_OP_DONE_BIT] = 1'b1;
        end
        `SRCC_CMD_EVT_STAT_QRY: begin
          evt_clear = query_ok;
        end
        `SRCC_CMD_RESET: begin
          // Masks, latch and status byte stay as they are.
          nxt_meter_reset = 1'b1;
        end
        default: begin
          evt_clear = 1'b0;
        end
      endcase
    end
    if (query_ok) begin
      nxt_message_available_flag = 1'b1;
    end else if (term_sent) begin
      nxt_message_available_flag = 1'b0;
    end
    new_events = new_events & `SRCC_EVT_USED_MASK;
    // New events win over a clear in the same cycle.
    nxt_event_status_latch =
      (evt_clear ? 8'h00 : event_status_latch_ff) | new_events;
    if ((new_events & ~event_status_latch_ff & event_enable_mask_ff)
        != 8'h00) begin
      nxt_event_summary_flag = 1'b1;
    end else if (evt_clear) begin
      nxt_event_summary_flag = 1'b0;
    end else begin
      nxt_event_summary_flag = event_summary_flag_ff;
    end
    // A rise of the master summary wins over a serial poll clear.
    if (mss_rise) begin
      nxt_request_service_flag = 1'b1;
    end else if (spoll_req) begin
      nxt_request_service_flag = 1'b0;
    end else begin
      nxt_request_service_flag = request_service_flag_ff;
    end
  end

  // ============================================================
  // Answer assembly
  // ============================================================
  always @* begin
    case (cmd_code)
      `SRCC_CMD_SVC_MASK_QRY:
        dec_sel = dec_text(service_request_mask_ff &
                           `SRCC_SVC_MASK_BIT6_CLR);
      `SRCC_CMD_EVT_MASK_QRY:
        dec_sel = dec_text(event_enable_mask_ff);
      `SRCC_CMD_EVT_STAT_QRY:
        dec_sel = dec_text(event_status_latch_ff);
      `SRCC_CMD_SUMMARY_QRY:
        dec_sel = dec_text(status_bits |
          {1'b0, master_summary_flag, 6'h00});
      `SRCC_CMD_OP_DONE_QRY:
        dec_sel = {`SRCC_LEN_TWO, `SRCC_CHR_ONE,
                   `SRCC_CHR_LF, 16'h0000};
      default:
        dec_sel = {(`SRCC_CNT_W+`SRCC_DEC_W){1'b0}};
    endcase
    q_load = 1'b0;
    q_len = dec_sel[`SRCC_CNT_W+`SRCC_DEC_W-1:`SRCC_DEC_W];
    q_data = {dec_sel[`SRCC_DEC_W-1:0], {PAD_DEC{1'b0}}};
    if (ctrl_c) begin
      q_load = 1'b1;
      q_len = `SRCC_LEN_THREE;
      q_data = {`SRCC_CHR_CR, `SRCC_CHR_LF, PROMPT_CHAR,
                {PAD_PROMPT{1'b0}}};
    end else if (query_ok) begin
      q_load = 1'b1;
      if (cmd_code == `SRCC_CMD_IDENT_QRY) begin
        q_len = IDN_RESP_LEN;
        q_data = {IDN_TEXT, `SRCC_CHR_LF, {PAD_IDN{1'b0}}};
      end
    end
  end

  srcc_out_queue #(
    .DEPTH(Q_DEPTH)
  ) u_queue (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .flush(q_flush),
    .load(q_load),
    .load_len(q_len),
    .load_data(q_data),
    .out_ready(out_ready),
    .out_valid(out_valid),
    .out_data(out_data),
    .term_sent(term_sent)
  );

  // ============================================================
  // Registers
  // ============================================================
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      service_request_mask_ff <= `SRCC_MASK_RESET;
      event_enable_mask_ff <= `SRCC_MASK_RESET;
      event_status_latch_ff <= `SRCC_EVT_RESET;
      event_summary_flag_ff <= 1'b0;
      message_available_flag_ff <= 1'b0;
      request_service_flag_ff <= 1'b0;
      mss_prev_ff <= 1'b0;
      spoll_byte_ff <= 8'h00;
      srq_ff <= 1'b0;
      meter_reset_ff <= 1'b0;
    end else begin
      service_request_mask_ff <= nxt_service_request_mask;
      event_enable_mask_ff <= nxt_event_enable_mask;
      event_status_latch_ff <= nxt_event_status_latch;
      event_summary_flag_ff <= nxt_event_summary_flag;
      message_available_flag_ff <= nxt_message_available_flag;
      request_service_flag_ff <= nxt_request_service_flag;
      mss_prev_ff <= master_summary_flag;
      srq_ff <= nxt_request_service_flag;
      meter_reset_ff <= nxt_meter_reset;
      if (spoll_req) begin
        spoll_byte_ff <= status_bits |
          {1'b0, request_service_flag_ff, 6'h00};
      end
    end
  end

endmodule // srcc_status_core

`default_nettype wire

// File: testbench/srcc_core_properties.sv
// Purpose: Concurrent checks on the status core ports.
// Assumes: Bound to every srcc_status_core instance.
// Notes:   Sees ports only; command taking follows the hand-over contract.
`timescale 1ns/1ps
`default_nettype none
module srcc_core_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [15:0] cmd_value,
  input wire logic dev_clear,
  input wire logic ctrl_c,
  input wire logic query_err_evt,
  input wire logic dev_err_evt,
  input wire logic cmd_err_evt,
  input wire logic spoll_req,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic [7:0] spoll_byte_ff,
  input wire logic srq_ff,
  input wire logic meter_reset_ff,
  input wire logic [7:0] service_request_mask_ff,
  input wire logic [7:0] event_status_latch_ff
);
  logic tk;
  logic no_evt;
  logic [7:0] val_lo;
  // A command in a clear cycle is dropped, so it is no cause.
  assign tk = cmd_valid & ~dev_clear & ~ctrl_c;
  assign no_evt = ~query_err_evt & ~dev_err_evt & ~cmd_err_evt;
  assign val_lo = cmd_value[7:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Assertions
  // ==========================================================
  mask_write_a: assert property (
    tk && cmd_code == 4'h8 && cmd_value <= 16'h00FF |=>
    service_request_mask_ff == ($past(val_lo) & 8'hBF))
    else $error("service mask not loaded");
  mask_bit_six_a: assert property (
    service_request_mask_ff[6] == 1'b0) else $error("mask bit 6 set");
  range_refuse_a: assert property (
    tk && (cmd_code == 4'h1 || cmd_code == 4'h8) && cmd_value > 16'h00FF
    |=> event_status_latch_ff[4] && $stable(service_request_mask_ff))
    else $error("out of range value not refused");
  op_done_set_a: assert property (
    tk && cmd_code == 4'h5 |=> event_status_latch_ff[0])
    else $error("operation complete bit not set");
  status_read_a: assert property (
    tk && cmd_code == 4'h3 && !out_valid && no_evt |=>
    event_status_latch_ff == 8'h00 && out_valid)
    else $error("event latch not cleared by read");
  unused_evt_a: assert property (
    event_status_latch_ff[1] == 1'b0 && event_status_latch_ff[6] == 1'b0)
    else $error("unused event bit set");
  op_done_qry_a: assert property (
    tk && cmd_code == 4'h6 && !out_valid |=>
    out_valid && out_data == 8'h31) else $error("op done answer wrong");
  srq_cause_a: assert property (
    $rose(srq_ff) |-> $past(service_request_mask_ff) != 8'h00 ||
    $past(service_request_mask_ff, 2) != 8'h00)
    else $error("service request with empty mask");
  poll_byte_a: assert property (
    spoll_req |=> spoll_byte_ff[6] == $past(srq_ff) &&
    spoll_byte_ff[3:0] == 4'h0 && !spoll_byte_ff[7])
    else $error("poll byte wrong");
  meter_reset_a: assert property (
    tk && cmd_code == 4'h7 |=> meter_reset_ff &&
    $stable(service_request_mask_ff) ##1 !meter_reset_ff)
    else $error("reset command pulse wrong");
  dev_clear_a: assert property (
    dev_clear && !ctrl_c |=> service_request_mask_ff == 8'h00 && !out_valid)
    else $error("device clear incomplete");
  break_key_a: assert property (
    ctrl_c |=> service_request_mask_ff == 8'h00 && out_valid &&
    out_data == 8'h0D) else $error("control-C handling wrong");
endmodule // srcc_core_props
bind srcc_status_core srcc_core_props u_props (.core_clk(core_clk),
  .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_value(cmd_value), .dev_clear(dev_clear), .ctrl_c(ctrl_c),
  .query_err_evt(query_err_evt), .dev_err_evt(dev_err_evt),
  .cmd_err_evt(cmd_err_evt), .spoll_req(spoll_req),
  .out_valid(out_valid), .out_data(out_data),
  .spoll_byte_ff(spoll_byte_ff), .srq_ff(srq_ff),
  .meter_reset_ff(meter_reset_ff),
  .service_request_mask_ff(service_request_mask_ff),
  .event_status_latch_ff(event_status_latch_ff));
`default_nettype wire

// File: testbench/srcc_host_model.sv
// Purpose: Host controller that reads answer bytes from the core.
// Assumes: One answer at a time; a line ends at a line feed.
// Notes:   With stall_en high the host takes a byte one cycle in four.
`timescale 1ns/1ps
`default_nettype none
module srcc_host_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic stall_en,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  output logic [255:0] line_ff,
  output logic line_done_ff
);
  logic fresh_ff;
  logic [1:0] cnt_ff;
  logic take;
  assign take = out_valid & out_ready;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
      line_ff <= 256'h0;
      line_done_ff <= 1'b0;
      fresh_ff <= 1'b1;
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      out_ready <= !stall_en || cnt_ff == 2'h3;
      line_done_ff <= take && out_data == 8'h0A;
      // An idle gap starts a new line, so a bare prompt stands alone.
      if (take) begin
        line_ff <= fresh_ff ? {248'h0, out_data} : {line_ff[247:0], out_data};
        fresh_ff <= out_data == 8'h0A;
      end else if (!out_valid) begin
        fresh_ff <= 1'b1;
      end
    end
  end
endmodule // srcc_host_model
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the status core.
// Assumes: Commands arrive parsed, one per pulse of cmd_valid.
// Notes:   Answers are gathered by the host model and compared as text.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  // Identity text; the value is arbitrary.
  localparam [8*26-1:0] IDN = "ACME,MTR1,0000001,1.0 D1.0";
  logic core_clk = 0, rst_b = 0, cmd_valid = 0, cmd_first = 0;
  logic dev_clear = 0, ctrl_c = 0, query_err_evt = 0, dev_err_evt = 0;
  logic cmd_err_evt = 0, spoll_req = 0, stall_en = 0, first = 1;
  logic [3:0] cmd_code = 4'h0;
  logic [15:0] cmd_value = 16'h0000, v;
  logic out_ready, out_valid, srq, meter_reset, line_done;
  logic [7:0] out_data, spoll, mask, latch;
  logic [255:0] line;
  int fail_count = 0, tests_run = 0, seed = 25, i, j;
  always #20 core_clk = ~core_clk;
  srcc_status_core #(.IDN_LEN(26), .IDN_TEXT(IDN)) DUT (.core_clk(core_clk),
    .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_value(cmd_value), .cmd_first(cmd_first), .dev_clear(dev_clear),
    .ctrl_c(ctrl_c), .query_err_evt(query_err_evt),
    .dev_err_evt(dev_err_evt), .cmd_err_evt(cmd_err_evt),
    .spoll_req(spoll_req), .out_ready(out_ready), .out_valid(out_valid),
    .out_data(out_data), .spoll_byte_ff(spoll), .srq_ff(srq),
    .meter_reset_ff(meter_reset), .service_request_mask_ff(mask),
    .event_status_latch_ff(latch));
  srcc_host_model u_host (.core_clk(core_clk), .rst_b(rst_b),
    .stall_en(stall_en), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .line_ff(line), .line_done_ff(line_done));
  // ==========================================================
  // Expectations and drivers
  // ==========================================================
  function automatic [255:0] dec_line(input [15:0] x);
    logic [7:0] h, t, o;
    h = 8'h30 + 8'(x / 100);
    t = 8'h30 + 8'((x / 10) % 10);
    o = 8'h30 + 8'(x % 10);
    if (x >= 100) dec_line = {224'h0, h, t, o, 8'h0A};
    else if (x >= 10) dec_line = {232'h0, t, o, 8'h0A};
    else dec_line = {240'h0, o, 8'h0A};
  endfunction
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cmd(input [3:0] c, input [15:0] x);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_value <= x;
    cmd_first <= first;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task wait_line;
    for (j = 0; j < 300 && line_done !== 1'b1; j++) begin
      @(posedge core_clk);
      #1;
    end
    if (line_done !== 1'b1) begin
      fail_count++;
      conclude;
    end
  endtask
  task query(input [3:0] c, input [255:0] e);
    cmd(c, 16'h0000);
    wait_line;
    `CHK(line, e)
  endtask
  task strobe(input int k);
    @(posedge core_clk);
    case (k)
      0: dev_clear <= 1'b1;
      1: ctrl_c <= 1'b1;
      2: query_err_evt <= 1'b1;
      3: dev_err_evt <= 1'b1;
      4: cmd_err_evt <= 1'b1;
      default: spoll_req <= 1'b1;
    endcase
    @(posedge core_clk);
    {dev_clear, ctrl_c, query_err_evt, dev_err_evt} <= 4'h0;
    {cmd_err_evt, spoll_req} <= 2'h0;
    #1;
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1;
    `CHK(mask, 8'h00)
    `CHK(latch, 8'h80)
    query(4'h3, dec_line(16'd128));
    `CHK(latch, 8'h00)
    query(4'h3, dec_line(16'd0));
    $display("test power-up done");
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'd48 : (i == 1) ? 16'd255 : $random(seed) & 16'hFF;
      stall_en <= i[0];
      cmd(4'h8, v);
      `CHK(mask, v[7:0] & 8'hBF)
      query(4'h9, dec_line(v & 16'h00BF));
    end
    $display("test service mask done");
    cmd(4'h1, 16'd77);
    cmd(4'h1, 16'd300);
    cmd(4'h8, 16'd256);
    `CHK(latch[4], 1'b1)
    `CHK(mask, v[7:0] & 8'hBF)
    query(4'h2, dec_line(16'd77));
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'd255 : (i == 1) ? 16'd0 : $random(seed) & 16'hFF;
      cmd(4'h1, v);
      query(4'h2, dec_line(v));
    end
    $display("test event mask done");
    cmd(4'hF, 16'h0000);
    for (i = 2; i < 5; i++) strobe(i);
    `CHK(latch & 8'h3C, 8'h3C)
    cmd(4'h0, 16'h0000);
    `CHK(latch, 8'h00)
    $display("test clear status done");
    cmd(4'h1, 16'd1);
    cmd(4'h8, 16'd32);
    strobe(5);
    `CHK(srq, 1'b0)
    cmd(4'h5, 16'h0000);
    `CHK(latch[0], 1'b1)
    for (j = 0; j < 10 && srq !== 1'b1; j++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(srq, 1'b1)
    query(4'hA, dec_line(16'd96));
    strobe(5);
    @(posedge core_clk);
    #1;
    `CHK(spoll[6], 1'b1)
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(srq, 1'b0)
    query(4'h3, dec_line(16'd1));
    query(4'hA, dec_line(16'd0));
    $display("test service request done");
    cmd(4'h8, 16'd16);
    query(4'h6, dec_line(16'd1));
    `CHK(srq, 1'b1)
    // A clear status that is not first in its line keeps a pending answer.
    cmd(4'h6, 16'h0000);
    first = 1'b0;
    cmd(4'h0, 16'h0000);
    first = 1'b1;
    wait_line;
    `CHK(line, dec_line(16'd1))
    cmd(4'h7, 16'h0000);
    `CHK(meter_reset, 1'b1)
    `CHK(mask, 8'h10)
    strobe(0);
    `CHK(mask, 8'h00)
    cmd(4'h8, 16'd48);
    strobe(1);
    wait_line;
    `CHK(line[15:0], 16'h0D0A)
    repeat (8) @(posedge core_clk);
    #1;
    `CHK(line[7:0], 8'h3E)
    `CHK(mask, 8'h00)
    query(4'h4, {IDN, 8'h0A});
    $display("test clears and identity done");
    conclude;
  end
endmodule // tb_top
`default_nettype wire
